/* File: csf_pkg.sv */
// Constants for the charger status and fault register group.
// Assumes the serial front end and the register logic share one 100 MHz clock.
// Operation
// R1: Status bits 7/6 show input overvoltage, input valid.
// R2: Status bit 5 shows input current limiting.
// R3: Status bit 4 shows die temperature limiting.
// R4: Bit 3 latches charge done past recharge threshold.
// R5: Bits 2:0 carry eight charger state codes.
// R6: Second status bits 7:5 carry thermistor state.
// R7: Recharge info active when auto-recharge disabled, complete.
// R8: When active, bit 3 shows battery below threshold.
// R9: Second status bits 2:0 carry battery state.
// R10: Fault bit 3 latches battery short until cleared.
// R11: Fault bit 1 latches lower overtemperature fault.
// R12: Fault bit 0 latches higher overtemperature fault.
// R13: Writing one or power cycling clears fault bits.
// R14: Unused bits read zero; status writes ignored.
package csf_pkg;

  // Register offsets on the serial bus.
  localparam logic [7:0] CSF_ADDR_STATUS1 = 8'h0b;
  localparam logic [7:0] CSF_ADDR_STATUS2 = 8'h0c;
  localparam logic [7:0] CSF_ADDR_FAULT   = 8'h0d;

  // Bus device address; the value is arbitrary.
  localparam logic [6:0] CSF_DEV_ADDR = 7'h14;

  // First status register field positions.
  localparam int CSF_S1_OV_BIT    = 7;
  localparam int CSF_S1_VALID_BIT = 6;
  localparam int CSF_S1_ILIM_BIT  = 5;
  localparam int CSF_S1_TLIM_BIT  = 4;
  localparam int CSF_S1_DONE_BIT  = 3;

  // Second status register field positions.
  localparam int CSF_S2_THERM_LSB = 5;
  localparam int CSF_S2_RCH_BIT   = 3;

  // Fault register field positions.
  localparam int CSF_F_SHORT_BIT = 3;
  localparam int CSF_F_OTLO_BIT  = 1;
  localparam int CSF_F_OTHI_BIT  = 0;

  // Reset values.
  localparam logic [7:0] CSF_RST_BYTE  = 8'h00;
  localparam logic [2:0] CSF_RST_FAULT = 3'h0;

  // Charger state codes.
  localparam logic [2:0] CSF_CHG_OFF      = 3'h0;
  localparam logic [2:0] CSF_CHG_TRICKLE  = 3'h1;
  localparam logic [2:0] CSF_CHG_FAST_CC  = 3'h2;
  localparam logic [2:0] CSF_CHG_FAST_CV  = 3'h3;
  localparam logic [2:0] CSF_CHG_COMPLETE = 3'h4;
  localparam logic [2:0] CSF_CHG_LDO      = 3'h5;
  localparam logic [2:0] CSF_CHG_TIMEOUT  = 3'h6;
  localparam logic [2:0] CSF_CHG_BATDET   = 3'h7;

  // Serial engine states.
  typedef enum logic [2:0] {
    CSF_IDLE,
    CSF_ADDR,
    CSF_PTR,
    CSF_WDATA,
    CSF_ACK,
    CSF_RDATA,
    CSF_RACK
  } csf_state_t;

endpackage : csf_pkg

/* File: csf_regs.sv */
// Status and fault register group with its two-wire serial slave.
// Assumes status inputs come from charger logic on clk_sys_in; bus pins are asynchronous.
`timescale 1ns/1ps

module csf_regs
(
  // Clock and reset.
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // Two-wire serial bus; data is open drain.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  // Charger status from the core.
  input  wire logic       input_overvoltage_flag_in,
  input  wire logic       input_valid_flag_in,
  input  wire logic       input_current_limited_flag_in,
  input  wire logic       die_temp_limited_flag_in,
  input  wire logic [2:0] charger_state_code_in,
  input  wire logic [2:0] thermistor_state_code_in,
  input  wire logic       auto_recharge_disable_in,
  input  wire logic       below_recharge_threshold_in,
  input  wire logic [2:0] battery_state_code_in,
  // Fault events and power cycle.
  input  wire logic       battery_short_fault_in,
  input  wire logic       overtemp_low_fault_in,
  input  wire logic       overtemp_high_fault_in,
  input  wire logic       input_power_cycle_in,
  // Decoded flags for the core.
  output logic            charge_done_latch_out,
  output logic            recharge_needed_flag_out
);

  // Three-stage synchronisers for the bus pins.
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic       scl_filt_q;          // Filtered clock level.
  logic       sda_filt_q;          // Filtered data level.
  logic       scl_prev_q;          // Previous filtered clock.
  logic       sda_prev_q;          // Previous filtered data.
  // Serial engine.
  csf_pkg::csf_state_t state_q;
  csf_pkg::csf_state_t ack_next_q; // State taken after an acknowledge slot.
  logic [3:0] bit_cnt_q;           // Bits seen in the current byte.
  logic [7:0] shift_q;             // Shift register for both directions.
  logic [7:0] ptr_q;               // Register pointer, auto-incremented.
  logic       master_ack_q;        // Master acknowledged the last read byte.
  logic       sda_drive_q;         // High while the slave pulls data low.
  // Register contents.
  logic [7:0] status1_q;
  logic [7:0] status2_q;
  logic [2:0] fault_q;             // Short, lower and higher overtemperature.
  logic       done_q;
  logic       rch_active;
  // Bus events.
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       wr_strobe;           // One-cycle write of shift_q to ptr_q.
  logic [7:0] rd_byte;             // Byte selected by the pointer.
  logic [2:0] clr_mask;            // Fault bits cleared this cycle.

  localparam logic [2:0] CSF_NONE = 3'h0;  // Empty clear mask.

  // A pin level counts only once the second and third stages agree, which rejects glitches.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_filt_q <= 1'b1;
      sda_filt_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      if (scl_sync_q[1] == scl_sync_q[2])
      begin
        scl_filt_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2])
      begin
        sda_filt_q <= sda_sync_q[2];
      end
      scl_prev_q <= scl_filt_q;
      sda_prev_q <= sda_filt_q;
    end
  end

  // Edge and condition detection on the filtered levels.
  assign scl_rise  = scl_filt_q && !scl_prev_q;
  assign scl_fall  = !scl_filt_q && scl_prev_q;
  assign bus_start = scl_filt_q && scl_prev_q && !sda_filt_q && sda_prev_q;
  assign bus_stop  = scl_filt_q && scl_prev_q && sda_filt_q && !sda_prev_q;
  assign wr_strobe = scl_fall && (state_q == csf_pkg::CSF_WDATA) && (bit_cnt_q == 4'h8);

  // Read mux; unmapped addresses and unused bits return zero.
  always_comb
  begin
    unique case (ptr_q)
      csf_pkg::CSF_ADDR_STATUS1: rd_byte = status1_q;
      csf_pkg::CSF_ADDR_STATUS2: rd_byte = status2_q;
      // Short sits at bit 3 and bit 2 stays unused, so the byte is not a plain extension.
      csf_pkg::CSF_ADDR_FAULT:   rd_byte = {4'h0, fault_q[2], 1'b0, fault_q[1:0]};  // [R10] [R14]
      default:                   rd_byte = csf_pkg::CSF_RST_BYTE;  // [R14]
    endcase
  end

  // Serial engine: bits are sampled on clock rise and data changes on clock fall.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q      <= csf_pkg::CSF_IDLE;
      ack_next_q   <= csf_pkg::CSF_IDLE;
      bit_cnt_q    <= 4'h0;
      shift_q      <= csf_pkg::CSF_RST_BYTE;
      ptr_q        <= csf_pkg::CSF_RST_BYTE;
      master_ack_q <= 1'b0;
      sda_drive_q  <= 1'b0;
    end
    else if (bus_start)
    begin
      // A start, repeated or not, always restarts address reception.
      state_q     <= csf_pkg::CSF_ADDR;
      bit_cnt_q   <= 4'h0;
      sda_drive_q <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_q     <= csf_pkg::CSF_IDLE;
      sda_drive_q <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (state_q == csf_pkg::CSF_RACK)
      begin
        master_ack_q <= !sda_filt_q;
      end
      else if (state_q != csf_pkg::CSF_IDLE && state_q != csf_pkg::CSF_ACK)
      begin
        // In read mode the shift is only a count; data was put out on the fall.
        if (state_q != csf_pkg::CSF_RDATA)
        begin
          shift_q <= {shift_q[6:0], sda_filt_q};
        end
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      unique case (state_q)
        csf_pkg::CSF_IDLE:
        begin
          sda_drive_q <= 1'b0;
        end
        csf_pkg::CSF_ADDR:
        begin
          if (bit_cnt_q == 4'h8)
          begin
            // Answer only to our own address; otherwise stay quiet until the next start.
            if (shift_q[7:1] == csf_pkg::CSF_DEV_ADDR)
            begin
              ack_next_q  <= shift_q[0] ? csf_pkg::CSF_RDATA : csf_pkg::CSF_PTR;
              state_q     <= csf_pkg::CSF_ACK;
              sda_drive_q <= 1'b1;
            end
            else
            begin
              state_q <= csf_pkg::CSF_IDLE;
            end
          end
        end
        csf_pkg::CSF_PTR:
        begin
          if (bit_cnt_q == 4'h8)
          begin
            ptr_q       <= shift_q;
            ack_next_q  <= csf_pkg::CSF_WDATA;
            state_q     <= csf_pkg::CSF_ACK;
            sda_drive_q <= 1'b1;
          end
        end
        csf_pkg::CSF_WDATA:
        begin
          if (bit_cnt_q == 4'h8)
          begin
            // The register update happens on wr_strobe in this same cycle.
            ptr_q       <= ptr_q + 8'h01;
            ack_next_q  <= csf_pkg::CSF_WDATA;
            state_q     <= csf_pkg::CSF_ACK;
            sda_drive_q <= 1'b1;
          end
        end
        csf_pkg::CSF_ACK:
        begin
          bit_cnt_q <= 4'h0;
          state_q   <= ack_next_q;
          if (ack_next_q == csf_pkg::CSF_RDATA)
          begin
            // Snapshot the byte so it cannot change while it is shifted out.
            shift_q     <= {rd_byte[6:0], 1'b0};
            sda_drive_q <= !rd_byte[7];
          end
          else
          begin
            sda_drive_q <= 1'b0;
          end
        end
        csf_pkg::CSF_RDATA:
        begin
          if (bit_cnt_q == 4'h8)
          begin
            sda_drive_q <= 1'b0;
            ptr_q       <= ptr_q + 8'h01;
            state_q     <= csf_pkg::CSF_RACK;
          end
          else
          begin
            sda_drive_q <= !shift_q[7];
            shift_q     <= {shift_q[6:0], 1'b0};
          end
        end
        csf_pkg::CSF_RACK:
        begin
          // A not-acknowledge ends the read; the master then sends stop or start.
          if (master_ack_q)
          begin
            bit_cnt_q   <= 4'h0;
            state_q     <= csf_pkg::CSF_RDATA;
            shift_q     <= {rd_byte[6:0], 1'b0};
            sda_drive_q <= !rd_byte[7];
          end
          else
          begin
            state_q <= csf_pkg::CSF_IDLE;
          end
        end
      endcase
    end
  end

  // Open-drain data: the pin is only ever pulled low.
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = !sda_drive_q;

  // Status capture; the status registers take no bus writes at all.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      status1_q <= csf_pkg::CSF_RST_BYTE;
      status2_q <= csf_pkg::CSF_RST_BYTE;
    end
    else
    begin
      status1_q <= csf_pkg::CSF_RST_BYTE;  // [R14]
      status1_q[csf_pkg::CSF_S1_OV_BIT]    <= input_overvoltage_flag_in;      // [R1]
      status1_q[csf_pkg::CSF_S1_VALID_BIT] <= input_valid_flag_in;            // [R1]
      status1_q[csf_pkg::CSF_S1_ILIM_BIT]  <= input_current_limited_flag_in;  // [R2]
      status1_q[csf_pkg::CSF_S1_TLIM_BIT]  <= die_temp_limited_flag_in;       // [R3]
      status1_q[csf_pkg::CSF_S1_DONE_BIT]  <= done_q;                         // [R4]
      status1_q[2:0] <= charger_state_code_in;                               // [R5]
      status2_q <= csf_pkg::CSF_RST_BYTE;  // [R14]
      status2_q[csf_pkg::CSF_S2_THERM_LSB +: 3] <= thermistor_state_code_in;  // [R6]
      status2_q[csf_pkg::CSF_S2_RCH_BIT] <= rch_active && below_recharge_threshold_in;  // [R8]
      status2_q[2:0] <= battery_state_code_in;                                // [R9]
    end
  end

  // Recharge information is only meaningful after completion with auto-recharge off.
  assign rch_active = auto_recharge_disable_in
                      && (charger_state_code_in == csf_pkg::CSF_CHG_COMPLETE);  // [R7]

  // Charge done latches on completion and ignores the battery sagging below threshold.
  // It releases only when a new charge phase begins.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      done_q <= 1'b0;
    end
    else if (charger_state_code_in == csf_pkg::CSF_CHG_COMPLETE)
    begin
      done_q <= 1'b1;  // [R4]
    end
    else if (charger_state_code_in == csf_pkg::CSF_CHG_TRICKLE
             || charger_state_code_in == csf_pkg::CSF_CHG_FAST_CC
             || charger_state_code_in == csf_pkg::CSF_CHG_FAST_CV)
    begin
      done_q <= 1'b0;
    end
  end

  // Write-one-to-clear mask; zeros and unused bits leave faults untouched.
  always_comb
  begin
    clr_mask = CSF_NONE;
    if (input_power_cycle_in)
    begin
      clr_mask = 3'h7;  // [R13]
    end
    else if (wr_strobe && ptr_q == csf_pkg::CSF_ADDR_FAULT)
    begin
      clr_mask = {shift_q[csf_pkg::CSF_F_SHORT_BIT],
                  shift_q[csf_pkg::CSF_F_OTLO_BIT],
                  shift_q[csf_pkg::CSF_F_OTHI_BIT]};  // [R13]
    end
  end

  // Sticky faults; a detection in the clearing cycle wins so no event is lost.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fault_q <= csf_pkg::CSF_RST_FAULT;
    end
    else
    begin
      fault_q <= (fault_q & ~clr_mask)
                 | {battery_short_fault_in,    // [R10]
                    overtemp_low_fault_in,     // [R11]
                    overtemp_high_fault_in};   // [R12]
    end
  end

  // Flags offered back to the core.
  assign charge_done_latch_out    = status1_q[csf_pkg::CSF_S1_DONE_BIT];
  assign recharge_needed_flag_out = status2_q[csf_pkg::CSF_S2_RCH_BIT];

endmodule : csf_regs

/* File: csf_props.sv */
// Checker for the status register group, watching only the top ports.
// Assumes one clock domain and the bind below onto csf_regs.
`timescale 1ns/1ps

module csf_props
(
  // Clock and reset.
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  // Bus pins and charger inputs.
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n_out,
  input wire logic [2:0] charger_state_code_in,
  input wire logic       auto_recharge_disable_in,
  input wire logic       below_recharge_threshold_in,
  // Decoded flags.
  input wire logic       charge_done_latch_out,
  input wire logic       recharge_needed_flag_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  // The done output passes the latch and then the status register, two cycles in all.
  a_done_sets: assert property (charger_state_code_in == 3'h4 |-> ##2 charge_done_latch_out)
    else $error("done latch did not set");
  a_done_clears: assert property ((charger_state_code_in inside {3'h1, 3'h2, 3'h3})
    |-> ##2 !charge_done_latch_out)
    else $error("done latch did not clear");
  a_done_holds: assert property ((charger_state_code_in inside {3'h0, 3'h5, 3'h6, 3'h7})
    |-> ##2 $stable(charge_done_latch_out))
    else $error("done latch moved");
  a_rch_sets: assert property (auto_recharge_disable_in && charger_state_code_in == 3'h4
    && below_recharge_threshold_in |=> recharge_needed_flag_out)
    else $error("recharge flag did not set");
  a_rch_needs_dis: assert property (!auto_recharge_disable_in |=> !recharge_needed_flag_out)
    else $error("recharge flag with auto recharge on");
  a_rch_needs_done: assert property (charger_state_code_in != 3'h4
    |=> !recharge_needed_flag_out)
    else $error("recharge flag outside complete");
  a_rch_above: assert property (!below_recharge_threshold_in |=> !recharge_needed_flag_out)
    else $error("recharge flag above threshold");
  a_sda_value_low: assert property (sda_out == 1'b0)
    else $error("open drain value not low");
  a_drive_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("data drive moved with bus clock high");
endmodule : csf_props

bind csf_regs csf_props u_props (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
  .charger_state_code_in(charger_state_code_in),
  .auto_recharge_disable_in(auto_recharge_disable_in),
  .below_recharge_threshold_in(below_recharge_threshold_in),
  .charge_done_latch_out(charge_done_latch_out),
  .recharge_needed_flag_out(recharge_needed_flag_out));

/* File: csf_host.sv */
// Host model driving the two-wire bus as master.
// Assumes a pull-up on data; the model only pulls low or releases.
`timescale 1ns/1ps

module csf_host
(
  // Pacing clock.
  input  wire logic clk_in,
  // Bus pins; a 1 on sda_out releases the line.
  output logic      scl_out,
  output logic      sda_out,
  input  wire logic sda_in
);
  // The bus idles released.
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick

  // Data changes only with the clock low, so no false start or stop is seen.
  task automatic xbit(input logic b, output logic r);
    tick(2);
    sda_out = b;
    tick(8);
    scl_out = 1'b1;
    tick(10);
    r = sda_in;
    scl_out = 1'b0;
  endtask : xbit

  // Eight bits most significant first, then the ninth bit.
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic r);
    for (int i = 7; i >= 0; i--)
      xbit(d[i], q[i]);
    xbit(a, r);
  endtask : xbyte

  // Start, also usable as a repeated start.
  task automatic start;
    tick(2);
    sda_out = 1'b1;
    tick(8);
    scl_out = 1'b1;
    tick(10);
    sda_out = 1'b0;
    tick(10);
    scl_out = 1'b0;
  endtask : start

  task automatic stop;
    tick(2);
    sda_out = 1'b0;
    tick(8);
    scl_out = 1'b1;
    tick(10);
    sda_out = 1'b1;
    tick(10);
  endtask : stop

  // Register write; a returns the address acknowledge, low meaning taken.
  task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
                    output logic a);
    logic [7:0] q;
    logic       r;
    start();
    xbyte({dev, 1'b0}, 1'b1, q, a);
    xbyte(p, 1'b1, q, r);
    xbyte(d, 1'b1, q, r);
    stop();
  endtask : wr

  // Two-byte read from pointer p, acknowledging the first byte only.
  task automatic rd2(input logic [7:0] p, output logic [7:0] q0, output logic [7:0] q1);
    logic [7:0] q;
    logic       r;
    start();
    xbyte({csf_pkg::CSF_DEV_ADDR, 1'b0}, 1'b1, q, r);
    xbyte(p, 1'b1, q, r);
    start();
    xbyte({csf_pkg::CSF_DEV_ADDR, 1'b1}, 1'b1, q, r);
    xbyte(8'hff, 1'b0, q0, r);
    xbyte(8'hff, 1'b1, q1, r);
    stop();
  endtask : rd2
endmodule : csf_host

/* File: test_csf_regs.sv */
// Testbench for csf_regs with a host model on the serial bus.
// Assumes inputs move on the falling clock edge; rows run in order for the done latch.
`timescale 1ns/1ps

module test_csf_regs;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        scl, host_sda, sda, sda_o, sda_oe_n, done, rch, ack, pwr = 1'b0;
  logic [3:0]  flags = 4'h0;
  logic [2:0]  st = 3'h0, th = 3'h0, bat = 3'h0, flt = 3'h0;
  logic        auto_recharge_disable = 1'b0, below = 1'b0;
  logic [7:0]  q0, q1;
  logic [35:0] r;
  int          err_count = 0, samples_checked = 0, cyc = 0;
  // Row: flags, state, thermistor, {disable, below, 00}, battery, status1, status2.
  logic [35:0] rows [10] = '{36'h8_0000_8000, 36'h4_1101_4121, 36'h2_22C2_2242,
    36'h1_3343_1363, 36'h4_44C4_4C8C, 36'hF_4784_FCE4, 36'h0_5740_0DE0,
    36'h0_6000_0E00, 36'h0_71C1_0F21, 36'h0_1000_0100};

  always #5 clk_sys_in = ~clk_sys_in;
  // A released line reads high through the pull-up.
  assign sda = host_sda & (sda_oe_n | sda_o);

  csf_host host (.clk_in(clk_sys_in), .scl_out(scl), .sda_out(host_sda), .sda_in(sda));
  csf_regs dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .input_overvoltage_flag_in(flags[3]),
    .input_valid_flag_in(flags[2]), .input_current_limited_flag_in(flags[1]),
    .die_temp_limited_flag_in(flags[0]), .charger_state_code_in(st),
    .thermistor_state_code_in(th), .auto_recharge_disable_in(auto_recharge_disable),
    .below_recharge_threshold_in(below), .battery_state_code_in(bat),
    .battery_short_fault_in(flt[2]), .overtemp_low_fault_in(flt[1]),
    .overtemp_high_fault_in(flt[0]), .input_power_cycle_in(pwr),
    .charge_done_latch_out(done), .recharge_needed_flag_out(rch));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // The whole run needs about 21500 cycles; a hang stops at 50000, over twice that.
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      err_count++;
      stop_test();
    end
  end

  initial
  begin
    repeat (2) @(negedge clk_sys_in);
    chk({7'h0, sda_oe_n}, 8'h01);
    rst_n_in = 1'b1;
    repeat (8) @(negedge clk_sys_in);
    foreach (rows[i])
    begin
      r = rows[i];
      {flags, st, th, auto_recharge_disable, below, bat} = {r[35:32], r[30:28], r[26:24], r[23:22], r[18:16]};
      host.tick(4);
      host.rd2(csf_pkg::CSF_ADDR_STATUS1, q0, q1);
      chk(q0, r[15:8]);
      chk(q1, r[7:0]);
      chk({6'h0, done, rch}, {6'h0, r[11], r[3]});
    end
    $display("status rows done");
    flt = 3'h7;
    host.tick(1);
    flt = 3'h0;
    host.rd2(csf_pkg::CSF_ADDR_FAULT, q0, q1);
    chk(q0, 8'h0b);
    chk(q1, 8'h00);
    host.wr(csf_pkg::CSF_DEV_ADDR, csf_pkg::CSF_ADDR_FAULT, 8'h02, ack);
    chk({7'h0, ack}, 8'h00);
    host.rd2(csf_pkg::CSF_ADDR_FAULT, q0, q1);
    chk(q0, 8'h09);
    host.wr(csf_pkg::CSF_DEV_ADDR, csf_pkg::CSF_ADDR_FAULT, 8'h00, ack);
    host.wr(csf_pkg::CSF_DEV_ADDR, csf_pkg::CSF_ADDR_STATUS1, 8'hff, ack);
    host.wr(7'h15, csf_pkg::CSF_ADDR_FAULT, 8'h09, ack);
    chk({7'h0, ack}, 8'h01);
    host.rd2(csf_pkg::CSF_ADDR_STATUS1, q0, q1);
    chk(q0, 8'h01);
    host.rd2(csf_pkg::CSF_ADDR_FAULT, q0, q1);
    chk(q0, 8'h09);
    host.wr(csf_pkg::CSF_DEV_ADDR, csf_pkg::CSF_ADDR_FAULT, 8'h01, ack);
    host.rd2(csf_pkg::CSF_ADDR_FAULT, q0, q1);
    chk(q0, 8'h08);
    pwr = 1'b1;
    host.tick(1);
    pwr = 1'b0;
    host.rd2(csf_pkg::CSF_ADDR_FAULT, q0, q1);
    chk(q0, 8'h00);
    // A short still present while software clears it must stay latched.
    flt = 3'h4;
    host.wr(csf_pkg::CSF_DEV_ADDR, csf_pkg::CSF_ADDR_FAULT, 8'h08, ack);
    flt = 3'h0;
    host.rd2(csf_pkg::CSF_ADDR_FAULT, q0, q1);
    chk(q0, 8'h08);
    $display("fault tests done");
    // A mid-run reset drops every latched fault and releases the data line.
    flt = 3'h3;
    host.tick(1);
    flt = 3'h0;
    rst_n_in = 1'b0;
    host.tick(2);
    chk({6'h0, done, sda_oe_n}, 8'h01);
    rst_n_in = 1'b1;
    host.rd2(csf_pkg::CSF_ADDR_FAULT, q0, q1);
    chk(q0, 8'h00);
    $display("reset test done");
    stop_test();
  end
endmodule : test_csf_regs
